// ### design/lmc_defs.svh
// Register map, field positions, reset values and timing for the mode and reset controller
`ifndef LMC_DEFS_SVH
`define LMC_DEFS_SVH

`define LMC_GLOBAL_CONTROL_ADDR       8'h00
`define LMC_UNDERVOLTAGE_CONTROL_ADDR 8'h2a
`define LMC_SOFT_RESET_COMMAND_ADDR   8'h2f
`define LMC_MIXING_CONTROL_ADDR       8'h46

`define LMC_SOFT_RESET_KEY            8'hae

`define LMC_CHIP_ACTIVE_BIT           0
`define LMC_UV_MON_DIS_BIT            0
`define LMC_UV_PROT_DIS_BIT           1
`define LMC_UV_FLAG_BIT               2
`define LMC_PWR_UP_STATUS_BIT         3
`define LMC_LOW_POWER_EN_BIT          1

`define LMC_GLOBAL_CONTROL_RST        8'h00
`define LMC_UNDERVOLTAGE_CONTROL_RST  8'h00
`define LMC_MIXING_CONTROL_RST        8'h00

`define LMC_CLK_PERIOD_NS             20
`define LMC_CMD_WAIT_NS               2000000
`define LMC_CMD_WAIT_CYCLES ((`LMC_CMD_WAIT_NS + `LMC_CLK_PERIOD_NS - 1) / `LMC_CLK_PERIOD_NS)

`endif

// ### design/lmc_pkg.sv
// Types shared by the mode and reset controller
package lmc_pkg;
    typedef enum logic [1:0] {
        mode_standby   = 2'h0,
        mode_active    = 2'h1,
        mode_low_power = 2'h3
    } lmc_mode_t;
endpackage

// ### design/lmc_ctrl_if.sv
// Control bits and events passed between register file and mode controller
`timescale 1ns/1ps
`default_nettype none
interface lmc_ctrl_if;
    logic chip_active;
    logic uv_mon_en;
    logic uv_prot_en;
    logic low_power_enable;
    logic soft_reset;
    logic uv_trip;
    logic uv_clear_chip;
    modport regs (output chip_active, uv_mon_en, uv_prot_en, low_power_enable, soft_reset,
                  input uv_trip, uv_clear_chip);
    modport ctrl (input chip_active, uv_mon_en, uv_prot_en, low_power_enable, soft_reset,
                  output uv_trip, uv_clear_chip);
endinterface
`default_nettype wire

// ### design/lmc_regfile.sv
// Page 0 registers touched by mode and reset control
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defs.svh"
module lmc_regfile
    import lmc_pkg::*;
(
    input  wire logic       ref_clk,    // 50 MHz clock
    input  wire logic       rst,        // Power-on reset
    input  wire logic       accept,     // Commands allowed
    input  wire logic       wr_en,      // Write strobe
    input  wire logic       rd_en,      // Read strobe
    input  wire logic [7:0] addr,       // Register address
    input  wire logic [7:0] wdata,      // Write data
    output logic      [7:0] rdata,      // Read data, one cycle after rd_en
    lmc_ctrl_if.regs        ctl         // Control bits to mode controller
);
    logic [7:0] global_control;
    logic [7:0] undervoltage_control;
    logic [7:0] mixing_control;
    logic [7:0] next_global_control;
    logic [7:0] next_undervoltage_control;
    logic [7:0] next_mixing_control;
    logic [7:0] next_rdata;
    logic       wr_ok;
    logic       rd_ok;
    logic       srst;

    assign wr_ok = wr_en && accept;
    assign rd_ok = rd_en && accept;
    assign srst  = wr_ok && addr == `LMC_SOFT_RESET_COMMAND_ADDR
                   && wdata == `LMC_SOFT_RESET_KEY;

    assign ctl.soft_reset       = srst;
    assign ctl.chip_active      = global_control[`LMC_CHIP_ACTIVE_BIT];
    assign ctl.uv_mon_en        = !undervoltage_control[`LMC_UV_MON_DIS_BIT];
    assign ctl.uv_prot_en       = !undervoltage_control[`LMC_UV_PROT_DIS_BIT];
    assign ctl.low_power_enable = mixing_control[`LMC_LOW_POWER_EN_BIT];

    always_comb begin
        next_global_control       = global_control;
        next_undervoltage_control = undervoltage_control;
        next_mixing_control       = mixing_control;
        next_rdata                = 8'h00;
        if (rd_ok) begin
            unique case (addr)
                `LMC_GLOBAL_CONTROL_ADDR:       next_rdata = global_control;
                `LMC_UNDERVOLTAGE_CONTROL_ADDR: next_rdata = undervoltage_control;
                `LMC_MIXING_CONTROL_ADDR:       next_rdata = mixing_control;
                default:                        next_rdata = 8'h00;
            endcase
            // Flags clear once seen by the host
            if (addr == `LMC_UNDERVOLTAGE_CONTROL_ADDR) begin
                next_undervoltage_control[`LMC_UV_FLAG_BIT]       = 1'b0;
                next_undervoltage_control[`LMC_PWR_UP_STATUS_BIT] = 1'b0;
            end
        end
        if (wr_ok) begin
            unique case (addr)
                `LMC_GLOBAL_CONTROL_ADDR:  next_global_control = wdata;
                `LMC_MIXING_CONTROL_ADDR:  next_mixing_control = wdata;
                `LMC_UNDERVOLTAGE_CONTROL_ADDR: begin
                    next_undervoltage_control[`LMC_UV_MON_DIS_BIT]  = wdata[`LMC_UV_MON_DIS_BIT];
                    next_undervoltage_control[`LMC_UV_PROT_DIS_BIT] = wdata[`LMC_UV_PROT_DIS_BIT];
                    next_undervoltage_control[7:4]                  = wdata[7:4];
                end
                default: ;
            endcase
        end
        // Hardware events win over a same-cycle clear or register write, but a soft reset wins over them
        if (ctl.uv_trip) begin
            next_undervoltage_control[`LMC_UV_FLAG_BIT] = 1'b1;
        end
        if (ctl.uv_clear_chip) begin
            next_global_control[`LMC_CHIP_ACTIVE_BIT] = 1'b0;
        end
        if (srst) begin
            next_global_control       = `LMC_GLOBAL_CONTROL_RST;
            next_undervoltage_control = `LMC_UNDERVOLTAGE_CONTROL_RST;
            next_undervoltage_control[`LMC_PWR_UP_STATUS_BIT] = 1'b1;
            next_mixing_control       = `LMC_MIXING_CONTROL_RST;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            global_control       <= `LMC_GLOBAL_CONTROL_RST;
            undervoltage_control <= `LMC_UNDERVOLTAGE_CONTROL_RST
                                    | (8'h01 << `LMC_PWR_UP_STATUS_BIT);
            mixing_control       <= `LMC_MIXING_CONTROL_RST;
            rdata                <= 8'h00;
        end else begin
            global_control       <= next_global_control;
            undervoltage_control <= next_undervoltage_control;
            mixing_control       <= next_mixing_control;
            rdata                <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ### design/lmc_mode_ctrl.sv
// Operating mode and reset controller of the matrix LED driver
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defs.svh"
module lmc_mode_ctrl
    import lmc_pkg::*;
#(
    parameter int CMD_WAIT_CYCLES = `LMC_CMD_WAIT_CYCLES
) (
    input  wire logic       ref_clk,        // 50 MHz clock
    input  wire logic       rst,            // Power-on reset, supply below threshold
    input  wire logic       en_pin,         // Enable pin level
    input  wire logic       uv_event,       // Supply under UVLO threshold
    input  wire logic       over_temperature_event, // Thermal shutdown active
    input  wire logic       pwm_nonzero,    // Some PWM in active frame nonzero
    input  wire logic       wr_en,          // Register write strobe
    input  wire logic       rd_en,          // Register read strobe
    input  wire logic [7:0] addr,           // Register address
    input  wire logic [7:0] wdata,          // Register write data
    output logic      [7:0] rdata,          // Register read data
    output logic            cmd_accept,     // Commands are taken
    output lmc_mode_t       mode,           // Current operating mode
    output logic            analog_enable,  // Analog blocks powered
    output logic            low_power_mode  // Low-power sub-state active
);
    localparam int WAIT_W = $clog2(CMD_WAIT_CYCLES + 1);

    lmc_ctrl_if ctl ();

    lmc_mode_t         next_mode;
    logic [WAIT_W-1:0] wait_cnt;
    logic [WAIT_W-1:0] next_wait_cnt;
    logic              standby_cond;

    lmc_regfile u_regs (
        .ref_clk (ref_clk),
        .rst     (rst),
        .accept  (cmd_accept),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .addr    (addr),
        .wdata   (wdata),
        .rdata   (rdata),
        .ctl     (ctl)
    );

    // Registers never see the mode, so standby keeps contents and access
    assign ctl.uv_trip       = uv_event && ctl.uv_mon_en;
    assign ctl.uv_clear_chip = ctl.uv_trip && ctl.uv_prot_en;

    assign standby_cond = !en_pin || !ctl.chip_active || over_temperature_event
                          || ctl.uv_clear_chip;

    assign cmd_accept     = wait_cnt == '0;
    assign analog_enable  = mode != mode_standby;
    assign low_power_mode = mode == mode_low_power;

    always_comb begin
        next_wait_cnt = wait_cnt;
        if (ctl.soft_reset) begin
            next_wait_cnt = WAIT_W'(CMD_WAIT_CYCLES);
        end else if (wait_cnt != '0) begin
            next_wait_cnt = wait_cnt - 1'b1;
        end
    end

    always_comb begin
        next_mode = mode;
        unique case (mode)
            mode_standby: begin
                if (!standby_cond) begin
                    next_mode = mode_active;
                end
            end
            mode_active: begin
                if (standby_cond) begin
                    next_mode = mode_standby;
                end else if (ctl.low_power_enable && !pwm_nonzero) begin
                    next_mode = mode_low_power;
                end
            end
            mode_low_power: begin
                if (standby_cond) begin
                    next_mode = mode_standby;
                end else if (pwm_nonzero || !ctl.low_power_enable) begin
                    next_mode = mode_active;
                end
            end
            default: next_mode = mode_standby;
        endcase
        if (ctl.soft_reset) begin
            next_mode = mode_standby;
        end
    end

    // Reset is the POR itself, so a supply dip restarts everything
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode     <= mode_standby;
            wait_cnt <= WAIT_W'(CMD_WAIT_CYCLES);
        end else begin
            mode     <= next_mode;
            wait_cnt <= next_wait_cnt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_por_standby;
        $fell(rst) |-> mode == mode_standby && !cmd_accept;
    endproperty
    a_por_standby: assert property (p_por_standby) else $error("not standby after POR");

    property p_en_low;
        !en_pin |=> mode == mode_standby;
    endproperty
    a_en_low: assert property (p_en_low) else $error("enable low did not force standby");

    property p_ot;
        over_temperature_event |=> mode == mode_standby && !analog_enable;
    endproperty
    a_ot: assert property (p_ot) else $error("over temperature did not force standby");

    property p_active_needs;
        mode != mode_standby |-> $past(en_pin) && $past(ctl.chip_active);
    endproperty
    a_active_needs: assert property (p_active_needs) else $error("active without enable");

    property p_lp_needs_en;
        mode == mode_low_power |-> $past(ctl.low_power_enable) && !$past(pwm_nonzero);
    endproperty
    a_lp_needs_en: assert property (p_lp_needs_en) else $error("low power not allowed");

    property p_lp_enter;
        mode == mode_active && !standby_cond && !ctl.soft_reset
            && ctl.low_power_enable && !pwm_nonzero |=> low_power_mode;
    endproperty
    a_lp_enter: assert property (p_lp_enter) else $error("low power not entered");

    property p_lp_exit;
        mode == mode_low_power && pwm_nonzero |=> mode != mode_low_power;
    endproperty
    a_lp_exit: assert property (p_lp_exit) else $error("low power not left");

    property p_uv_clear;
        ctl.uv_clear_chip |=> !ctl.chip_active && mode == mode_standby;
    endproperty
    a_uv_clear: assert property (p_uv_clear) else $error("undervoltage kept chip active");

    property p_lp_to_standby;
        mode == mode_low_power && standby_cond |=> mode == mode_standby;
    endproperty
    a_lp_to_standby: assert property (p_lp_to_standby) else $error("low power exit wrong");

    property p_srst;
        ctl.soft_reset |=> mode == mode_standby && !ctl.chip_active && !cmd_accept [*8];
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset not applied");

    property p_standby_dark;
        mode == mode_standby |-> !analog_enable && !low_power_mode;
    endproperty
    a_standby_dark: assert property (p_standby_dark) else $error("standby powered");

    property p_refused;
        !cmd_accept && !ctl.uv_clear_chip |=> $stable(ctl.chip_active);
    endproperty
    a_refused: assert property (p_refused) else $error("refused write landed");

    property p_wait_load;
        ctl.soft_reset |=> wait_cnt == WAIT_W'(CMD_WAIT_CYCLES);
    endproperty
    a_wait_load: assert property (p_wait_load) else $error("wait not reloaded");

    property p_wait_step;
        wait_cnt != '0 && !ctl.soft_reset |=> wait_cnt == $past(wait_cnt) - 1'b1;
    endproperty
    a_wait_step: assert property (p_wait_step) else $error("wait not counting");

    property p_wake;
        mode == mode_standby && !standby_cond && !ctl.soft_reset |=> mode == mode_active;
    endproperty
    a_wake: assert property (p_wake) else $error("active not entered");

    property p_srst_regs;
        ctl.soft_reset |=> !ctl.low_power_enable && ctl.uv_mon_en && ctl.uv_prot_en;
    endproperty
    a_srst_regs: assert property (p_srst_regs) else $error("soft reset kept controls");

    property p_lp_sub;
        mode == mode_low_power |-> $past(mode) != mode_standby;
    endproperty
    a_lp_sub: assert property (p_lp_sub) else $error("low power from standby");

    property p_chip_off;
        !ctl.chip_active |=> mode == mode_standby;
    endproperty
    a_chip_off: assert property (p_chip_off) else $error("chip bit low not standby");

    property p_lp_off;
        mode == mode_low_power && !ctl.low_power_enable |=> mode != mode_low_power;
    endproperty
    a_lp_off: assert property (p_lp_off) else $error("low power kept when disabled");

    c_active:    cover property (mode == mode_standby ##1 mode == mode_active);
    c_low_power: cover property (mode == mode_active ##1 mode == mode_low_power);
    c_srst:      cover property (ctl.soft_reset);
    c_uv:        cover property (ctl.uv_clear_chip && mode != mode_standby);
endmodule
`default_nettype wire

// ### tb/lmc_host_model.sv
// Register host model: single-byte accesses launched at the falling edge
`timescale 1ns/1ps
`default_nettype none
module lmc_host_model (
    input  wire logic       ref_clk,    // Device clock
    input  wire logic       cmd_accept, // Device takes commands
    input  wire logic [7:0] rdata,      // Read data
    output logic            wr_en,      // Write strobe
    output logic            rd_en,      // Read strobe
    output logic      [7:0] addr,       // Register address
    output logic      [7:0] wdata       // Write data
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // Host holds off until the device takes commands again
    task automatic wait_ready;
        int n;
        n = 0;
        while (cmd_accept !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    // Released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic hold);
        @(negedge ref_clk);
        if (hold) begin
            wait_ready();
        end
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge ref_clk);
        wr_en = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        wait_ready();
        rd_en = 1'b1;
        addr = a;
        @(negedge ref_clk);
        d = rdata;
        rd_en = 1'b0;
        addr = ~a;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the mode and reset controller
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defs.svh"
module tb_top
    import lmc_pkg::*;
;
    localparam int WAIT = 20;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       en_pin = 1'b0;
    logic       uv_event = 1'b0;
    logic       ot = 1'b0;
    logic       pwm_nz = 1'b0;
    logic       wr_en, rd_en, cmd_accept, analog_enable, low_power_mode;
    logic [7:0] addr, wdata, rdata, d;
    lmc_mode_t  mode;
    int         error_cnt = 0;
    int         n_compared = 0;
    int         cyc = 0;

    lmc_host_model i_host (.ref_clk(ref_clk), .cmd_accept(cmd_accept), .rdata(rdata),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
    lmc_mode_ctrl #(.CMD_WAIT_CYCLES(WAIT)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .en_pin(en_pin), .uv_event(uv_event), .over_temperature_event(ot),
        .pwm_nonzero(pwm_nz), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .cmd_accept(cmd_accept), .mode(mode),
        .analog_enable(analog_enable), .low_power_mode(low_power_mode));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 140 cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Mode, analog power and low-power flag judged together
    task automatic mchk(input lmc_mode_t m, input int n);
        repeat (n) @(negedge ref_clk);
        chk("mode", {4'h0, low_power_mode, analog_enable, mode},
            {4'h0, m == mode_low_power, m != mode_standby, m});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d);
        chk("register", d, exp);
    endtask

    task automatic t_por;
        int n;
        n = 0;
        mchk(mode_standby, 0);
        chk("accept", {7'h0, cmd_accept}, 8'h00);
        while (cmd_accept !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        chk("wait", {7'h0, n >= WAIT - 1 && n <= WAIT + 1}, 8'h01);
        rchk(`LMC_UNDERVOLTAGE_CONTROL_ADDR, 8'h08);
        rchk(`LMC_UNDERVOLTAGE_CONTROL_ADDR, 8'h00);
        rchk(`LMC_GLOBAL_CONTROL_ADDR, 8'h00);
        rchk(`LMC_MIXING_CONTROL_ADDR, 8'h00);
        $display("test por done");
    endtask

    task automatic t_modes;
        en_pin = 1'b1;
        i_host.wr(`LMC_GLOBAL_CONTROL_ADDR, 8'h01, 1'b1);
        mchk(mode_standby, 0);
        mchk(mode_active, 1);
        en_pin = 1'b0;
        mchk(mode_standby, 1);
        rchk(`LMC_GLOBAL_CONTROL_ADDR, 8'h01);
        en_pin = 1'b1;
        mchk(mode_active, 1);
        ot = 1'b1;
        mchk(mode_standby, 1);
        ot = 1'b0;
        mchk(mode_active, 1);
        mchk(mode_active, 3);
        i_host.wr(`LMC_GLOBAL_CONTROL_ADDR, 8'h00, 1'b1);
        mchk(mode_standby, 1);
        $display("test modes done");
    endtask

    task automatic t_low;
        i_host.wr(`LMC_GLOBAL_CONTROL_ADDR, 8'h01, 1'b1);
        mchk(mode_active, 1);
        i_host.wr(`LMC_MIXING_CONTROL_ADDR, 8'h02, 1'b1);
        mchk(mode_low_power, 1);
        pwm_nz = 1'b1;
        mchk(mode_active, 1);
        pwm_nz = 1'b0;
        mchk(mode_low_power, 1);
        i_host.wr(`LMC_MIXING_CONTROL_ADDR, 8'h00, 1'b1);
        mchk(mode_active, 1);
        i_host.wr(`LMC_MIXING_CONTROL_ADDR, 8'h02, 1'b1);
        mchk(mode_low_power, 1);
        en_pin = 1'b0;
        mchk(mode_standby, 1);
        en_pin = 1'b1;
        mchk(mode_active, 1);
        $display("test low power done");
    endtask

    task automatic t_uv;
        uv_event = 1'b1;
        mchk(mode_standby, 2);
        uv_event = 1'b0;
        rchk(`LMC_GLOBAL_CONTROL_ADDR, 8'h00);
        rchk(`LMC_UNDERVOLTAGE_CONTROL_ADDR, 8'h04);
        i_host.wr(`LMC_GLOBAL_CONTROL_ADDR, 8'h01, 1'b1);
        mchk(mode_active, 1);
        // Protection off: flag only, chip stays on
        i_host.wr(`LMC_UNDERVOLTAGE_CONTROL_ADDR, 8'h02, 1'b1);
        uv_event = 1'b1;
        mchk(mode_low_power, 2);
        uv_event = 1'b0;
        rchk(`LMC_UNDERVOLTAGE_CONTROL_ADDR, 8'h06);
        rchk(`LMC_GLOBAL_CONTROL_ADDR, 8'h01);
        $display("test undervoltage done");
    endtask

    task automatic t_soft;
        i_host.wr(`LMC_SOFT_RESET_COMMAND_ADDR, 8'h55, 1'b1);
        rchk(`LMC_MIXING_CONTROL_ADDR, 8'h02);
        i_host.wr(`LMC_SOFT_RESET_COMMAND_ADDR, `LMC_SOFT_RESET_KEY, 1'b1);
        chk("accept", {7'h0, cmd_accept}, 8'h00);
        mchk(mode_standby, 1);
        // Written before the wait ends, so it must be dropped
        i_host.wr(`LMC_GLOBAL_CONTROL_ADDR, 8'h01, 1'b0);
        rchk(`LMC_GLOBAL_CONTROL_ADDR, 8'h00);
        rchk(`LMC_MIXING_CONTROL_ADDR, 8'h00);
        rchk(`LMC_UNDERVOLTAGE_CONTROL_ADDR, 8'h08);
        rchk(`LMC_SOFT_RESET_COMMAND_ADDR, 8'h00);
        $display("test soft reset done");
    endtask

    task automatic t_dip;
        i_host.wr(`LMC_MIXING_CONTROL_ADDR, 8'h02, 1'b1);
        i_host.wr(`LMC_GLOBAL_CONTROL_ADDR, 8'h01, 1'b1);
        mchk(mode_active, 1);
        rst = 1'b1;
        mchk(mode_standby, 1);
        chk("accept", {7'h0, cmd_accept}, 8'h00);
        rst = 1'b0;
        rchk(`LMC_MIXING_CONTROL_ADDR, 8'h00);
        rchk(`LMC_UNDERVOLTAGE_CONTROL_ADDR, 8'h08);
        mchk(mode_standby, 0);
        $display("test supply dip done");
    endtask

    initial begin
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        t_por();
        t_modes();
        t_low();
        t_uv();
        t_soft();
        t_dip();
        summarize();
    end
endmodule
`default_nettype wire
